// File: design/amp_control_register_map.sv
`timescale 1ns/1ps
// Operation
// - 2048 consecutive zero samples enter auto sleep
// - one nonzero sample wakes from auto sleep
// - bit 7 enables auto sleep, resets 1
// - bit 6 powers off battery sensing, resets 0
// - bit 5 powers off voltage sensing, resets 0
// - bit 4 is read-write current sense power-down
// - power control at 0x00 resets to 0x81
// - current sense off when 1, resets 0
// - bit 0 sleeps all but control interface
module amp_control_register_map
    import amp_regs_pkg::*;
#(
    parameter int ZERO_RUN_LEN = amp_regs_pkg::ZERO_RUN // zeros before sleep, at most 4096
)
(
    input wire logic clk, // 10 MHz device clock
    input wire logic reset, // async, active high
    input wire logic clk_en, // freezes all state when low
    input wire logic wr_en, // register write strobe
    input wire logic [amp_regs_pkg::ADDR_W-1:0] wr_addr, // write address
    input wire logic [amp_regs_pkg::DATA_W-1:0] wr_data, // write data
    input wire logic [amp_regs_pkg::ADDR_W-1:0] rd_addr, // read address
    output logic [amp_regs_pkg::DATA_W-1:0] rd_data, // registered read data
    input wire logic sample_valid, // one input audio sample present
    input wire logic [amp_regs_pkg::SAMPLE_W-1:0] sample_data, // audio sample
    input wire logic [7:0] battery_level, // measured battery value
    input wire logic [7:0] fault_a, // fault flags group a
    input wire logic [7:0] fault_b, // fault flags group b
    output logic auto_sleep, // device asleep from zero run
    output logic low_power, // whole device in low power
    output logic battery_sense_on, // battery sensing powered
    output logic voltage_sense_on, // voltage sensing powered
    output logic current_sense_on, // current sensing powered
    output logic boost_on, // boost converter powered
    output logic amp_on, // amplifier and converter powered
    output logic [7:0] reg_image [0:amp_regs_pkg::REG_COUNT-1] // all setup registers
);
    import amp_regs_pkg::*;

    typedef struct packed {
        logic [REG_COUNT-1:0][7:0] regs;
        logic [7:0] rd;
        logic [ZCOUNT_W-1:0] zeros;
        sleep_state_t sleep;
    } state_t;

    state_t state_reg;
    state_t state_next;

    logic zero_sample;
    logic [7:0] power_control;
    logic auto_enable;

    assign power_control = state_reg.regs[OFF_POWER_CONTROL[4:0]];
    assign auto_enable = power_control[BIT_AUTO_SLEEP_ENABLE];
    assign zero_sample = (sample_data == '0);

    function automatic state_t reset_state();
        state_t s;
        s = '0;
        for (int i = 0; i < REG_COUNT; i++)
        begin
            s.regs[i] = RESET_VALUES[i];
        end
        s.sleep = SLEEP_AWAKE;
        return s;
    endfunction

    // built once so the reset branch loads a plain constant
    localparam state_t RESET_STATE = reset_state();

    always_comb
    begin
        state_next = state_reg;
        // full compare, so unmapped offsets never alias onto a register
        if (wr_en)
        begin
            if (wr_addr == OFF_POWER_CONTROL)
            begin
                state_next.regs[OFF_POWER_CONTROL[4:0]] = wr_data;
            end
            else if (wr_addr == OFF_AMP_SENSE_SETUP)
            begin
                state_next.regs[OFF_AMP_SENSE_SETUP[4:0]] = wr_data;
            end
            else if (wr_addr == OFF_PLAYBACK_CONVERTER_SETUP)
            begin
                state_next.regs[OFF_PLAYBACK_CONVERTER_SETUP[4:0]] = wr_data;
            end
            else if (wr_addr == OFF_PLAYBACK_VOLUME)
            begin
                state_next.regs[OFF_PLAYBACK_VOLUME[4:0]] = wr_data;
            end
            else if (wr_addr == OFF_SERIAL_AUDIO_CONFIG_A)
            begin
                state_next.regs[OFF_SERIAL_AUDIO_CONFIG_A[4:0]] = wr_data;
            end
            else if (wr_addr == OFF_SERIAL_AUDIO_CONFIG_B)
            begin
                state_next.regs[OFF_SERIAL_AUDIO_CONFIG_B[4:0]] = wr_data;
            end
            else if (wr_addr == OFF_SLOT_PLACEMENT_ONE)
            begin
                state_next.regs[OFF_SLOT_PLACEMENT_ONE[4:0]] = wr_data;
            end
            else if (wr_addr == OFF_SLOT_PLACEMENT_TWO)
            begin
                state_next.regs[OFF_SLOT_PLACEMENT_TWO[4:0]] = wr_data;
            end
            else if (wr_addr == OFF_SLOT_PLACEMENT_THREE)
            begin
                state_next.regs[OFF_SLOT_PLACEMENT_THREE[4:0]] = wr_data;
            end
            else if (wr_addr == OFF_SLOT_PLACEMENT_FOUR)
            begin
                state_next.regs[OFF_SLOT_PLACEMENT_FOUR[4:0]] = wr_data;
            end
            else if (wr_addr == OFF_SLOT_PLACEMENT_FIVE)
            begin
                state_next.regs[OFF_SLOT_PLACEMENT_FIVE[4:0]] = wr_data;
            end
            else if (wr_addr == OFF_SLOT_PLACEMENT_SIX)
            begin
                state_next.regs[OFF_SLOT_PLACEMENT_SIX[4:0]] = wr_data;
            end
            else if (wr_addr == OFF_LIMITER_SETUP_A)
            begin
                state_next.regs[OFF_LIMITER_SETUP_A[4:0]] = wr_data;
            end
            else if (wr_addr == OFF_LIMITER_SETUP_B)
            begin
                state_next.regs[OFF_LIMITER_SETUP_B[4:0]] = wr_data;
            end
            else if (wr_addr == OFF_LIMITER_SETUP_C)
            begin
                state_next.regs[OFF_LIMITER_SETUP_C[4:0]] = wr_data;
            end
            else if (wr_addr == OFF_FAULT_RECOVERY_SETUP)
            begin
                state_next.regs[OFF_FAULT_RECOVERY_SETUP[4:0]] = wr_data;
            end
            else if (wr_addr == OFF_PULSE_DENSITY_SETUP)
            begin
                state_next.regs[OFF_PULSE_DENSITY_SETUP[4:0]] = wr_data;
            end
            else if (wr_addr == OFF_CLOCK_RATIO_SETUP)
            begin
                state_next.regs[OFF_CLOCK_RATIO_SETUP[4:0]] = wr_data;
            end
            else if (wr_addr == OFF_BOOST_SETUP_A)
            begin
                state_next.regs[OFF_BOOST_SETUP_A[4:0]] = wr_data;
            end
            else if (wr_addr == OFF_BOOST_SETUP_B)
            begin
                state_next.regs[OFF_BOOST_SETUP_B[4:0]] = wr_data;
            end
        end

        // live status is sampled into the read-only slots
        state_next.regs[OFF_BATTERY_LEVEL[4:0]] = battery_level;
        state_next.regs[OFF_FAULT_STATUS_A[4:0]] = fault_a;
        state_next.regs[OFF_FAULT_STATUS_B[4:0]] = fault_b;

        // read path; a read in the cycle of a write returns the old value
        if (rd_addr == OFF_POWER_CONTROL)
        begin
            state_next.rd = state_reg.regs[OFF_POWER_CONTROL[4:0]];
        end
        else if (rd_addr == OFF_AMP_SENSE_SETUP)
        begin
            state_next.rd = state_reg.regs[OFF_AMP_SENSE_SETUP[4:0]];
        end
        else if (rd_addr == OFF_PLAYBACK_CONVERTER_SETUP)
        begin
            state_next.rd = state_reg.regs[OFF_PLAYBACK_CONVERTER_SETUP[4:0]];
        end
        else if (rd_addr == OFF_PLAYBACK_VOLUME)
        begin
            state_next.rd = state_reg.regs[OFF_PLAYBACK_VOLUME[4:0]];
        end
        else if (rd_addr == OFF_SERIAL_AUDIO_CONFIG_A)
        begin
            state_next.rd = state_reg.regs[OFF_SERIAL_AUDIO_CONFIG_A[4:0]];
        end
        else if (rd_addr == OFF_SERIAL_AUDIO_CONFIG_B)
        begin
            state_next.rd = state_reg.regs[OFF_SERIAL_AUDIO_CONFIG_B[4:0]];
        end
        else if (rd_addr == OFF_SLOT_PLACEMENT_ONE)
        begin
            state_next.rd = state_reg.regs[OFF_SLOT_PLACEMENT_ONE[4:0]];
        end
        else if (rd_addr == OFF_SLOT_PLACEMENT_TWO)
        begin
            state_next.rd = state_reg.regs[OFF_SLOT_PLACEMENT_TWO[4:0]];
        end
        else if (rd_addr == OFF_SLOT_PLACEMENT_THREE)
        begin
            state_next.rd = state_reg.regs[OFF_SLOT_PLACEMENT_THREE[4:0]];
        end
        else if (rd_addr == OFF_SLOT_PLACEMENT_FOUR)
        begin
            state_next.rd = state_reg.regs[OFF_SLOT_PLACEMENT_FOUR[4:0]];
        end
        else if (rd_addr == OFF_SLOT_PLACEMENT_FIVE)
        begin
            state_next.rd = state_reg.regs[OFF_SLOT_PLACEMENT_FIVE[4:0]];
        end
        else if (rd_addr == OFF_SLOT_PLACEMENT_SIX)
        begin
            state_next.rd = state_reg.regs[OFF_SLOT_PLACEMENT_SIX[4:0]];
        end
        else if (rd_addr == OFF_BATTERY_LEVEL)
        begin
            state_next.rd = state_reg.regs[OFF_BATTERY_LEVEL[4:0]];
        end
        else if (rd_addr == OFF_LIMITER_SETUP_A)
        begin
            state_next.rd = state_reg.regs[OFF_LIMITER_SETUP_A[4:0]];
        end
        else if (rd_addr == OFF_LIMITER_SETUP_B)
        begin
            state_next.rd = state_reg.regs[OFF_LIMITER_SETUP_B[4:0]];
        end
        else if (rd_addr == OFF_LIMITER_SETUP_C)
        begin
            state_next.rd = state_reg.regs[OFF_LIMITER_SETUP_C[4:0]];
        end
        else if (rd_addr == OFF_FAULT_STATUS_A)
        begin
            state_next.rd = state_reg.regs[OFF_FAULT_STATUS_A[4:0]];
        end
        else if (rd_addr == OFF_FAULT_STATUS_B)
        begin
            state_next.rd = state_reg.regs[OFF_FAULT_STATUS_B[4:0]];
        end
        else if (rd_addr == OFF_FAULT_RECOVERY_SETUP)
        begin
            state_next.rd = state_reg.regs[OFF_FAULT_RECOVERY_SETUP[4:0]];
        end
        else if (rd_addr == OFF_PULSE_DENSITY_SETUP)
        begin
            state_next.rd = state_reg.regs[OFF_PULSE_DENSITY_SETUP[4:0]];
        end
        else if (rd_addr == OFF_CLOCK_RATIO_SETUP)
        begin
            state_next.rd = state_reg.regs[OFF_CLOCK_RATIO_SETUP[4:0]];
        end
        else if (rd_addr == OFF_BOOST_SETUP_A)
        begin
            state_next.rd = state_reg.regs[OFF_BOOST_SETUP_A[4:0]];
        end
        else if (rd_addr == OFF_BOOST_SETUP_B)
        begin
            state_next.rd = state_reg.regs[OFF_BOOST_SETUP_B[4:0]];
        end
        else
        begin
            // reset trigger has no action here; it and holes read zero
            state_next.rd = 8'h00;
        end

        if (!auto_enable)
        begin
            state_next.zeros = '0;
            state_next.sleep = SLEEP_AWAKE;
        end
        else if (sample_valid)
        begin
            case (state_reg.sleep)
                SLEEP_AWAKE:
                begin
                    if (!zero_sample)
                    begin
                        state_next.zeros = '0;
                    end
                    else if (state_reg.zeros == ZCOUNT_W'(ZERO_RUN_LEN - 1))
                    begin
                        // counter saturates here; no wrap while asleep
                        state_next.sleep = SLEEP_AUTO;
                    end
                    else
                    begin
                        state_next.zeros = state_reg.zeros + 1'b1;
                    end
                end
                SLEEP_AUTO:
                begin
                    if (!zero_sample)
                    begin
                        state_next.sleep = SLEEP_AWAKE;
                        state_next.zeros = '0;
                    end
                end
                default:
                begin
                    state_next.sleep = SLEEP_AWAKE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= RESET_STATE;
        end
        else if (clk_en)
        begin
            state_reg <= state_next;
        end
    end

    assign rd_data = state_reg.rd;
    assign auto_sleep = (state_reg.sleep == SLEEP_AUTO);
    // master sleep covers all but the control interface
    assign low_power = power_control[BIT_MASTER_SOFTWARE_SLEEP] || auto_sleep;
    assign battery_sense_on = !low_power && !power_control[BIT_BATTERY_SENSE_OFF];
    assign voltage_sense_on = !low_power && !power_control[BIT_VOLTAGE_SENSE_OFF];
    assign current_sense_on = !low_power && !power_control[BIT_CURRENT_SENSE_OFF];
    assign boost_on = !low_power && !power_control[BIT_BOOST_OFF];
    assign amp_on = !low_power && !power_control[BIT_AMP_OFF];

    always_comb
    begin
        for (int i = 0; i < REG_COUNT; i++)
        begin
            reg_image[i] = state_reg.regs[i];
        end
    end
endmodule

// File: shared/amp_regs_pkg.sv
package amp_regs_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int REG_COUNT = 23;
    localparam int ZERO_RUN = 2048;
    localparam int ZCOUNT_W = 12;
    localparam int SAMPLE_W = 24;

    localparam logic [7:0] OFF_POWER_CONTROL = 8'h00;
    localparam logic [7:0] OFF_AMP_SENSE_SETUP = 8'h01;
    localparam logic [7:0] OFF_PLAYBACK_CONVERTER_SETUP = 8'h02;
    localparam logic [7:0] OFF_PLAYBACK_VOLUME = 8'h03;
    localparam logic [7:0] OFF_SERIAL_AUDIO_CONFIG_A = 8'h04;
    localparam logic [7:0] OFF_SERIAL_AUDIO_CONFIG_B = 8'h05;
    localparam logic [7:0] OFF_SLOT_PLACEMENT_ONE = 8'h06;
    localparam logic [7:0] OFF_SLOT_PLACEMENT_TWO = 8'h07;
    localparam logic [7:0] OFF_SLOT_PLACEMENT_THREE = 8'h08;
    localparam logic [7:0] OFF_SLOT_PLACEMENT_FOUR = 8'h09;
    localparam logic [7:0] OFF_SLOT_PLACEMENT_FIVE = 8'h0A;
    localparam logic [7:0] OFF_SLOT_PLACEMENT_SIX = 8'h0B;
    localparam logic [7:0] OFF_BATTERY_LEVEL = 8'h0C;
    localparam logic [7:0] OFF_LIMITER_SETUP_A = 8'h0D;
    localparam logic [7:0] OFF_LIMITER_SETUP_B = 8'h0E;
    localparam logic [7:0] OFF_LIMITER_SETUP_C = 8'h0F;
    localparam logic [7:0] OFF_FAULT_STATUS_A = 8'h10;
    localparam logic [7:0] OFF_FAULT_STATUS_B = 8'h11;
    localparam logic [7:0] OFF_FAULT_RECOVERY_SETUP = 8'h12;
    localparam logic [7:0] OFF_PULSE_DENSITY_SETUP = 8'h13;
    localparam logic [7:0] OFF_CLOCK_RATIO_SETUP = 8'h14;
    localparam logic [7:0] OFF_BOOST_SETUP_A = 8'h15;
    localparam logic [7:0] OFF_BOOST_SETUP_B = 8'h16;
    localparam logic [7:0] OFF_LAST_RW = 8'h16;
    localparam logic [7:0] OFF_RESET_TRIGGER = 8'hFF;

    localparam int BIT_AUTO_SLEEP_ENABLE = 7;
    localparam int BIT_BATTERY_SENSE_OFF = 6;
    localparam int BIT_VOLTAGE_SENSE_OFF = 5;
    localparam int BIT_CURRENT_SENSE_OFF = 4;
    localparam int BIT_BOOST_OFF = 3;
    localparam int BIT_AMP_OFF = 2;
    localparam int BIT_MASTER_SOFTWARE_SLEEP = 0;

    localparam logic [7:0] RESET_VALUES [0:REG_COUNT-1] = '{
        8'h81, 8'h09, 8'h32, 8'h40, 8'h00, 8'h08, 8'h01, 8'h20,
        8'h32, 8'h07, 8'h07, 8'h07, 8'h00, 8'hA4, 8'h73, 8'h00,
        8'h00, 8'h00, 8'h30, 8'h40, 8'h11, 8'h03, 8'h00
    };

    typedef enum logic [0:0] {
        SLEEP_AWAKE = 1'b0,
        SLEEP_AUTO = 1'b1
    } sleep_state_t;
endpackage

// File: tb/amp_chk.sv
`timescale 1ns/1ps
module amp_chk (
    input wire logic clk, // clock
    input wire logic reset, // reset
    input wire logic clk_en, // enable
    input wire logic wr_en, // strobe
    input wire logic [7:0] wr_addr, // addr
    input wire logic [7:0] wr_data, // data
    input wire logic sample_valid, // strobe
    input wire logic [23:0] sample_data, // sample
    input wire logic auto_sleep, // asleep
    input wire logic low_power, // sleep
    input wire logic battery_sense_on, // on
    input wire logic voltage_sense_on, // on
    input wire logic current_sense_on, // on
    input wire logic [7:0] reg_image [0:22] // regs
);
    wire logic [7:0] pc = reg_image[0];
    wire logic zero_in = clk_en && sample_valid && sample_data == 24'h0;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence pc_wr; clk_en && wr_en && wr_addr == 8'h00; endsequence
    sequence wake_in; clk_en && sample_valid && sample_data != 24'h0 && pc[7]; endsequence
    a_pc_write: assert property (pc_wr |=> pc == $past(wr_data))
        else $error("write lost");
    a_low_power: assert property (low_power == (pc[0] || auto_sleep))
        else $error("low power");
    a_batt_sense: assert property (battery_sense_on == !(low_power || pc[6]))
        else $error("battery sense");
    a_volt_sense: assert property (voltage_sense_on == !(low_power || pc[5]))
        else $error("voltage sense");
    a_curr_sense: assert property (current_sense_on == !(low_power || pc[4]))
        else $error("current sense");
    a_auto_off: assert property (clk_en && !pc[7] |=> !auto_sleep)
        else $error("sleep disabled");
    a_wake_up: assert property (wake_in |=> !auto_sleep)
        else $error("no wake");
    a_sleep_cause: assert property ($rose(auto_sleep) |-> $past(zero_in))
        else $error("bad sleep");
    // counts the zero run independently so an early sleep is caught
    int zero_run_seen;
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            zero_run_seen <= 0;
        end
        else if (clk_en && (!pc[7] || (sample_valid && sample_data != 24'h0)))
        begin
            zero_run_seen <= 0;
        end
        else if (zero_in && zero_run_seen < 4096)
        begin
            zero_run_seen <= zero_run_seen + 1;
        end
    end
    a_sleep_run: assert property ($rose(auto_sleep) |-> zero_run_seen == 2048)
        else $error("sleep before full zero run");
endmodule
bind amp_control_register_map amp_chk u_chk (.*);

// File: tb/amp_control_register_map_tb_top.sv
`timescale 1ns/1ps
module amp_control_register_map_tb_top;
    logic clk = 0, reset = 1, sv = 0, we, asl, lp, bs, vs, cs, bo, ao;
    logic [23:0] sd = 0;
    logic [7:0] wa, wd, ra, rdat, g;
    logic [7:0] img [0:22];
    int miscompares = 0, n_tests = 0;
    always #50 clk = ~clk;
    amp_host host (.clk(clk), .wr_en(we), .wr_addr(wa), .wr_data(wd),
        .rd_addr(ra), .rd_data(rdat));
    amp_control_register_map dut (.clk(clk), .reset(reset), .clk_en(1'b1),
        .wr_en(we), .wr_addr(wa), .wr_data(wd), .rd_addr(ra), .rd_data(rdat),
        .sample_valid(sv), .sample_data(sd), .battery_level(8'h5A),
        .fault_a(8'h3C), .fault_b(8'h01), .auto_sleep(asl), .low_power(lp),
        .battery_sense_on(bs), .voltage_sense_on(vs), .current_sense_on(cs),
        .boost_on(bo), .amp_on(ao), .reg_image(img));
    task chk(input logic [7:0] x, e);
        n_tests++;
        if (x !== e)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, x, e);
        end
    endtask
    task feed(input int n, input logic [23:0] v);
        repeat (n)
        begin
            {sv, sd} = {1'b1, v};
            @(posedge clk) #1;
        end
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task t_reset;
        host.rd(8'h00, g);
        chk(g, 8'h81);
        chk({g[7], lp, bo, ao}, 8'h0C);
        for (int i = 0; i < 23; i++)
            if (i != 12 && i != 16 && i != 17)
                chk(img[i], amp_regs_pkg::RESET_VALUES[i]);
        host.rd(8'h0C, g);
        chk(g, 8'h5A);
        // unmapped offset must not alias onto the power register
        host.wr(8'h20, 8'h55);
        chk(img[0], 8'h81);
        host.rd(8'h10, g);
        chk(g, 8'h3C);
        host.rd(8'hFF, g);
        chk(g, 8'h00);
    endtask
    task t_bits;
        host.wr(8'h00, 8'h00);
        chk({lp, bs, vs, cs, bo, ao}, 8'h1F);
        host.wr(8'h00, 8'h40);
        chk({bs, vs, cs}, 8'h03);
        host.wr(8'h00, 8'h20);
        chk({bs, vs, cs}, 8'h05);
        host.wr(8'h00, 8'h10);
        chk({bs, vs, cs}, 8'h06);
        host.wr(8'h00, 8'h0C);
        chk({lp, bs, bo, ao}, 8'h04);
        host.wr(8'h00, 8'h01);
        chk({lp, bs, vs, cs, bo, ao}, 8'h20);
        host.wr(8'h00, 8'h70);
        chk({lp, bs, vs, cs}, 8'h00);
        host.rd(8'h00, g);
        chk(g, 8'h70);
    endtask
    task t_sleep;
        host.wr(8'h00, 8'h80);
        // one nonzero just short of the run must restart the count
        feed(2047, 0);
        feed(1, 1);
        feed(2047, 0);
        chk(8'(asl), 8'h00);
        feed(1, 0);
        chk({asl, lp}, 8'h03);
        feed(1, 24'h000100);
        chk({asl, lp}, 8'h00);
        feed(2048, 0);
        chk(8'(asl), 8'h01);
        sv = 0;
        host.wr(8'h00, 8'h00);
        host.rd(8'h00, g);
        chk({g[7:1], asl}, 8'h00);
        feed(2048, 0);
        chk(8'(asl), 8'h00);
        sv = 0;
        // count held at zero while disabled, so a full run is needed again
        host.wr(8'h00, 8'h80);
        feed(2047, 0);
        chk(8'(asl), 8'h00);
        feed(1, 0);
        chk(8'(asl), 8'h01);
        sv = 0;
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        #1 reset = 0;
        t_reset;
        t_bits;
        t_sleep;
        stop_test;
    end
    initial
    begin
        #2000000;
        miscompares++;
        stop_test;
    end
endmodule

// File: tb/amp_host.sv
`timescale 1ns/1ps
module amp_host (
    input wire logic clk, // clock
    output logic wr_en, // strobe
    output logic [7:0] wr_addr, // addr
    output logic [7:0] wr_data, // data
    output logic [7:0] rd_addr, // read addr
    input wire logic [7:0] rd_data // read data
);
    initial {wr_en, wr_addr, wr_data, rd_addr} = '0;
    task wr(input logic [7:0] a, d);
        @(posedge clk) #1;
        {wr_en, wr_addr, wr_data} = {1'b1, a, d};
        @(posedge clk) #1;
        wr_en = 0;
        // stale data inverted so it never passes as fresh
        wr_data = ~d;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk) #1;
        rd_addr = a;
        @(posedge clk) #1;
        d = rd_data;
    endtask
endmodule
